/* File: bench/tb_urb_top.sv */
`timescale 1ns/1ps
module tb_urb_top;
  localparam logic [11:0] PCON = {urb_pkg::IDX_PWR_BAUD, 2'b00};
  localparam logic [11:0] SYSTEM_FLAG_IRQ_ENABLE = {urb_pkg::IDX_SYSFLAG_IE, 2'b00};
  localparam logic [11:0] REP  = {urb_pkg::IDX_REPEATER, 2'b00};
  localparam logic [11:0] AUX  = {urb_pkg::IDX_BAUD_AUX, 2'b00};
  localparam logic [11:0] SCTL = {urb_pkg::IDX_SERIAL_CTL, 2'b00};
  localparam logic [11:0] IST  = {urb_pkg::IDX_IRQ_STATUS, 2'b00};
  localparam logic [11:0] IMSK = {urb_pkg::IDX_IRQ_MASK, 2'b00};
  logic        core_clk = 0, arst_n = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  logic [11:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rd_data;
  logic [1:0]  rd_resp, wr_resp;
  logic [3:0]  lvl = 4'hf, tx_func = 4'hf, rx_pin, tx_pin;
  logic        fe = 0, txd = 0, awready, wready, bvalid, arready, rvalid, rx_to_engine;
  logic        baud_double, extra_rate, serial_test_mode, mode0_tick, timer1_tick, serial_tx_irq;
  logic        sysflag_tx_irq, irq;
  logic [1:0]  bresp, rresp, serial_mode;
  logic [31:0] rdata;
  int          failures = 0, total_checks = 0;
  // ----------------------------------------------------------------
  // design, remote partner and clock
  // ----------------------------------------------------------------
  urb_top urb_top_i (.core_clk(core_clk), .arst_n(arst_n), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awready), .s_axi_wdata(wd), .s_axi_wstrb(4'h1), .s_axi_wvalid(wv), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .rx_pin(rx_pin), .tx_func(tx_func), .tx_pin(tx_pin), .rx_to_engine(rx_to_engine),
    .frame_err_evt(fe), .tx_done_flag(txd), .serial_mode(serial_mode), .baud_double(baud_double),
    .extra_rate(extra_rate), .serial_test_mode(serial_test_mode), .mode0_tick(mode0_tick),
    .timer1_tick(timer1_tick), .serial_tx_irq(serial_tx_irq), .sysflag_tx_irq(sysflag_tx_irq), .irq(irq));
  urb_remote_dev urb_remote_dev_i (.core_clk(core_clk), .line_lvl(lvl), .tx_pin(tx_pin), .rx_pin(rx_pin));
  // free-running 20 MHz clock
  always #25 core_clk = ~core_clk;
  // ----------------------------------------------------------------
  // report and bus tasks
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic hang(input string what);
    failures++;
    $display("Error %s expected answer seen timeout", what);
    final_report();
  endtask
  // write one register: address and data offered together, released as taken
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    int i;
    awa <= a; wd <= {24'h0, d}; awv <= 1; wv <= 1; bready <= 1;
    for (i = 0; i < 200; i++) begin
      @(posedge core_clk);
      if (awv && awready) awv <= 0;
      if (wv && wready) wv <= 0;
      if (bvalid === 1'b1) break;
    end
    if (i == 200) hang("write response");
    wr_resp = bresp;
    bready <= 0;
  endtask
  // read one register, keep data and response taken at the handshake edge
  task automatic rd(input logic [11:0] a);
    int i;
    ara <= a; arv <= 1; rready <= 1;
    for (i = 0; i < 200; i++) begin
      @(posedge core_clk);
      if (arv && arready) arv <= 0;
      if (rvalid === 1'b1) break;
    end
    if (i == 200) hang("read response");
    rd_data = rdata; rd_resp = rresp; rready <= 0;
  endtask
  // pulse counts over a 48-cycle window, after the dividers settle
  task automatic ticks(input int e0, input int e1);
    int n0, n1;
    n0 = 0; n1 = 0;
    repeat (12) @(posedge core_clk);
    repeat (48) begin
      @(posedge core_clk);
      n0 += (mode0_tick === 1'b1); n1 += (timer1_tick === 1'b1);
    end
    chk("mode0_tick count", n0, e0);
    chk("timer1_tick count", n1, e1);
  endtask
  task automatic frame_pulse();
    fe <= 1; @(posedge core_clk); fe <= 0; @(posedge core_clk);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge core_clk);
    arst_n <= 1;
    @(posedge core_clk);
    rd(PCON); chk("pwr_baud reset", rd_data, 32'h0);
    rd(REP); chk("repeater reset", rd_data, 32'h0);
    rd(AUX); chk("baud_aux reset", rd_data, 32'h0);
    rd(SYSTEM_FLAG_IRQ_ENABLE); chk("sysflag_ie reset", rd_data, 32'h0);
    rd(12'h004); chk("unmapped rresp", rd_resp, urb_pkg::RESP_SLVERR);
    wr(12'h004, 8'hff); chk("unmapped bresp", wr_resp, urb_pkg::RESP_SLVERR);
    wr(PCON, 8'h80); chk("pwr_baud bresp", wr_resp, urb_pkg::RESP_OKAY);
    @(posedge core_clk); chk("baud_double mode0", baud_double, 1'b0);
    wr(SCTL, 8'h40); @(posedge core_clk); chk("serial_mode", serial_mode, 2'b01);
    chk("baud_double mode1", baud_double, 1'b1);
    for (int ch = 0; ch < 4; ch++) begin
      wr(REP, {4'h5, 2'b00, 2'(ch)});
      lvl <= ~(4'h1 << ch);
      repeat (6) @(posedge core_clk);
      chk("rx_to_engine", rx_to_engine, 1'b0);
      chk("tx_pin repeat", tx_pin, 4'b1010);
      lvl <= 4'hf;
    end
    wr(SCTL, 8'h00); repeat (6) @(posedge core_clk); lvl <= 4'h0; repeat (6) @(posedge core_clk);
    chk("tx_pin mode0", tx_pin, 4'hf);
    ticks(4, 4); wr(AUX, 8'h28); ticks(24, 48);
    wr(AUX, 8'h10); @(posedge core_clk); chk("extra_rate", extra_rate, 1'b1);
    chk("serial_test_mode", serial_test_mode, 1'b0);
    frame_pulse(); wr(PCON, 8'h40); rd(SCTL); chk("flag with select clear", rd_data[7], 1'b1);
    wr(SCTL, 8'h00); rd(SCTL); chk("flag cleared", rd_data[7], 1'b0);
    wr(IMSK, 8'h01); frame_pulse(); @(posedge core_clk); chk("irq raised", irq, 1'b1);
    rd(SCTL); chk("flag set", rd_data[7], 1'b1);
    wr(IST, 8'h01); @(posedge core_clk); chk("irq cleared", irq, 1'b0);
    wr(IMSK, 8'h00); frame_pulse(); @(posedge core_clk); chk("irq masked", irq, 1'b0);
    txd <= 1; repeat (2) @(posedge core_clk);
    chk("serial_tx_irq", serial_tx_irq, 1'b1);
    chk("sysflag off", sysflag_tx_irq, 1'b0);
    wr(AUX, 8'h40); @(posedge core_clk); chk("serial_tx_irq blocked", serial_tx_irq, 1'b0);
    wr(SYSTEM_FLAG_IRQ_ENABLE, 8'h80); @(posedge core_clk); chk("sysflag_tx_irq", sysflag_tx_irq, 1'b1);
    final_report();
  end
endmodule

/* File: bench/urb_remote_dev.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// remote serial transmitters on the four receive candidate lines
// ----------------------------------------------------------------
module urb_remote_dev (
  input  wire logic       core_clk,
  input  wire logic [3:0] line_lvl,
  input  wire logic [3:0] tx_pin,
  output logic [3:0]      rx_pin = 4'hf
);
  // each remote line idles high and drives the level the bench asks for
  always @(posedge core_clk) begin
    rx_pin <= line_lvl;
  end
endmodule

/* File: rtl/urb_pkg.sv */
// What this block does
// [R1] baud doubling bit doubles the serial rate in modes 1, 2 and 3 only
// [R2] framing error select picks whether serial control bit 7 is mode bit 0 or flag
// [R3] framing error flag sets on every frame error, whatever the select bit
// [R4] four repeat enables each route the selected receive input to their transmit output
// [R5] two-bit channel select picks one of four receive candidate pins
// [R6] software writes zero to repeater control bits 3 and 2
// [R7] software always writes zero to the serial test mode bit
// [R8] transmit interrupt block bit removes transmit done from serial interrupt sources
// [R9] mode 0 bit clock is system clock over 12, or over 2 when selected
// [R10] extra rate selector enables the additional X2/X4 multiplication
// [R11] timer 1 internal clock is system clock over 12, or undivided when selected
// [R12] transmit sharing enable lets transmit done raise the system flag interrupt
// [R13] repeater works only in serial modes 1, 2 and 3, never in mode 0
// [R14] selected receive input feeds the engine and every enabled transmit output together
// [R15] receiver sets framing error on a bad stop bit; only software clears it
// [R16] non-repeating outputs carry normal transmit function; repeat delay is small and fixed
package urb_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [9:0] IDX_PWR_BAUD   = 10'h087;
  localparam logic [9:0] IDX_SYSFLAG_IE = 10'h08e;
  localparam logic [9:0] IDX_REPEATER   = 10'h0a2;
  localparam logic [9:0] IDX_BAUD_AUX   = 10'h0a3;
  localparam logic [9:0] IDX_SERIAL_CTL = 10'h098;
  localparam logic [9:0] IDX_IRQ_STATUS = 10'h0c0;
  localparam logic [9:0] IDX_IRQ_MASK   = 10'h0c1;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_PWR_BAUD   = 8'h00;
  localparam logic [7:0] RST_SYSFLAG_IE = 8'h00;
  localparam logic [7:0] RST_REPEATER   = 8'h00;
  localparam logic [7:0] RST_BAUD_AUX   = 8'h00;
  localparam logic [1:0] RST_SERIAL_CTL = 2'h0;
  localparam logic [1:0] RST_IRQ        = 2'h0;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BAUD_DOUBLE_EN_BIT   = 7;
  localparam int FRAME_ERR_SEL_BIT    = 6;
  localparam int TX_SHARE_SYSFLAG_BIT = 7;
  localparam logic [7:0] SYSFLAG_RW_MASK = 8'h8b;
  localparam int REPEAT_EN_LSB        = 4;
  localparam int RX_CHANNEL_LSB       = 0;
  localparam logic [7:0] REPEATER_RW_MASK = 8'hf3;
  localparam int SERIAL_TEST_MODE_BIT = 7;
  localparam int TX_IRQ_BLOCK_BIT     = 6;
  localparam int MODE0_RATE_SEL_BIT   = 5;
  localparam int EXTRA_RATE_SEL_BIT   = 4;
  localparam int TIMER1_CLK_SEL_BIT   = 3;
  localparam int SCTL_MODE_BIT0       = 7;
  localparam int SCTL_MODE_BIT1       = 6;
  localparam int IRQ_FRAME_ERR_BIT    = 0;
  localparam int IRQ_TX_DONE_BIT      = 1;

  // ----------------------------------------------------------------
  // clock dividers
  // ----------------------------------------------------------------
  localparam logic [3:0] DIV_SLOW = 4'hc;
  localparam logic [3:0] DIV_M0_FAST = 4'h2;
  localparam logic [3:0] DIV_NONE = 4'h1;

  // ----------------------------------------------------------------
  // bus responses
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* File: rtl/urb_prescaler.sv */
`timescale 1ns/1ps
// one-cycle tick every div_ratio clocks of core_clk
module urb_prescaler (
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  input  wire logic [3:0] div_ratio,
  output logic            tick
);

  logic [3:0] count;

  // ----------------------------------------------------------------
  // down counter, reload on terminal count
  // ----------------------------------------------------------------
  // a ratio change takes effect at the next reload, so no short tick
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= 4'h0;
      tick  <= 1'b0;
    end else if (count == 4'h0) begin
      count <= div_ratio - 4'h1;
      tick  <= 1'b1;
    end else begin
      count <= count - 4'h1;
      tick  <= 1'b0;
    end
  end

endmodule

/* File: rtl/urb_top.sv */
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
module urb_top #(
  parameter int N_CH = 4
) (
  input  wire logic            core_clk,
  input  wire logic            arst_n,
  // axi4-lite slave
  input  wire logic [11:0]     s_axi_awaddr,
  input  wire logic            s_axi_awvalid,
  output logic                 s_axi_awready,
  input  wire logic [31:0]     s_axi_wdata,
  input  wire logic [3:0]      s_axi_wstrb,
  input  wire logic            s_axi_wvalid,
  output logic                 s_axi_wready,
  output logic [1:0]           s_axi_bresp,
  output logic                 s_axi_bvalid,
  input  wire logic            s_axi_bready,
  input  wire logic [11:0]     s_axi_araddr,
  input  wire logic            s_axi_arvalid,
  output logic                 s_axi_arready,
  output logic [31:0]          s_axi_rdata,
  output logic [1:0]           s_axi_rresp,
  output logic                 s_axi_rvalid,
  input  wire logic            s_axi_rready,
  // serial pins and engine
  input  wire logic [N_CH-1:0] rx_pin,
  input  wire logic [N_CH-1:0] tx_func,
  output logic [N_CH-1:0]      tx_pin,
  output logic                 rx_to_engine,
  input  wire logic            frame_err_evt,
  input  wire logic            tx_done_flag,
  output logic [1:0]           serial_mode,
  output logic                 baud_double,
  output logic                 extra_rate,
  output logic                 serial_test_mode,
  output logic                 mode0_tick,
  output logic                 timer1_tick,
  output logic                 serial_tx_irq,
  output logic                 sysflag_tx_irq,
  output logic                 irq
);

  logic [7:0]      power_and_baud_control;
  logic [7:0]      system_flag_irq_enable;
  logic [7:0]      serial_repeater_control;
  logic [7:0]      serial_baud_aux_control;
  logic            serial_mode_bit0;
  logic            serial_mode_bit1;
  logic            framing_error_flag;
  logic [1:0]      irq_status;
  logic [1:0]      irq_mask;
  logic [11:0]     wr_addr;
  logic [7:0]      wr_byte;
  logic            wr_be;
  logic            wr_fire;
  logic [9:0]      wr_idx;
  logic [31:0]     next_rdata;
  logic            next_rhit;
  logic [N_CH-1:0] rx_meta;
  logic [N_CH-1:0] rx_sync;
  logic            sel_rx;
  logic            repeat_mode;
  logic            tx_done_d;
  logic            m0_raw;
  logic            t1_raw;

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  // address and data are taken in either order, the write fires when both are held
  assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_idx  = wr_addr[11:2];

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= urb_pkg::RESP_OKAY;
      wr_addr       <= 12'h000;
      wr_byte       <= 8'h00;
      wr_be         <= 1'b0;
    end else begin
      if (s_axi_awready && s_axi_awvalid) begin
        s_axi_awready <= 1'b0;
        wr_addr       <= s_axi_awaddr;
      end
      if (s_axi_wready && s_axi_wvalid) begin
        s_axi_wready <= 1'b0;
        wr_byte      <= s_axi_wdata[7:0];
        wr_be        <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        if (wr_idx == urb_pkg::IDX_PWR_BAUD || wr_idx == urb_pkg::IDX_SYSFLAG_IE ||
            wr_idx == urb_pkg::IDX_REPEATER || wr_idx == urb_pkg::IDX_BAUD_AUX ||
            wr_idx == urb_pkg::IDX_SERIAL_CTL || wr_idx == urb_pkg::IDX_IRQ_STATUS ||
            wr_idx == urb_pkg::IDX_IRQ_MASK) begin
          s_axi_bresp <= urb_pkg::RESP_OKAY;
        end else begin
          s_axi_bresp <= urb_pkg::RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  // reserved repeater bits 3..2 and flag-enable bits 6..4 and 2 are not stored
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      power_and_baud_control  <= urb_pkg::RST_PWR_BAUD;
      system_flag_irq_enable  <= urb_pkg::RST_SYSFLAG_IE;
      serial_repeater_control <= urb_pkg::RST_REPEATER;
      serial_baud_aux_control <= urb_pkg::RST_BAUD_AUX;
      irq_mask                <= urb_pkg::RST_IRQ;
    end else if (wr_fire && wr_be) begin
      if (wr_idx == urb_pkg::IDX_PWR_BAUD) begin
        power_and_baud_control <= wr_byte;
      end else if (wr_idx == urb_pkg::IDX_SYSFLAG_IE) begin
        system_flag_irq_enable <= wr_byte & urb_pkg::SYSFLAG_RW_MASK;
      end else if (wr_idx == urb_pkg::IDX_REPEATER) begin
        serial_repeater_control <= wr_byte & urb_pkg::REPEATER_RW_MASK; // R6
      end else if (wr_idx == urb_pkg::IDX_BAUD_AUX) begin
        serial_baud_aux_control <= wr_byte; // R7
      end else if (wr_idx == urb_pkg::IDX_IRQ_MASK) begin
        irq_mask <= wr_byte[1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // serial control: bit 7 is mode bit 0 or the framing error flag
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      serial_mode_bit0 <= urb_pkg::RST_SERIAL_CTL[0];
      serial_mode_bit1 <= urb_pkg::RST_SERIAL_CTL[1];
    end else if (wr_fire && wr_be && wr_idx == urb_pkg::IDX_SERIAL_CTL) begin
      serial_mode_bit1 <= wr_byte[urb_pkg::SCTL_MODE_BIT1];
      if (!power_and_baud_control[urb_pkg::FRAME_ERR_SEL_BIT]) begin
        serial_mode_bit0 <= wr_byte[urb_pkg::SCTL_MODE_BIT0]; // R2
      end
    end
  end

  // flag is set on any frame error, set wins over a software write
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      framing_error_flag <= 1'b0;
    end else if (frame_err_evt) begin
      framing_error_flag <= 1'b1; // R3 R15
    end else if (wr_fire && wr_be && wr_idx == urb_pkg::IDX_SERIAL_CTL &&
                 power_and_baud_control[urb_pkg::FRAME_ERR_SEL_BIT]) begin
      framing_error_flag <= wr_byte[urb_pkg::SCTL_MODE_BIT0]; // R2 R15
    end
  end

  // ----------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rhit  = 1'b1;
    if (s_axi_araddr[11:2] == urb_pkg::IDX_PWR_BAUD) begin
      next_rdata[7:0] = power_and_baud_control;
    end else if (s_axi_araddr[11:2] == urb_pkg::IDX_SYSFLAG_IE) begin
      next_rdata[7:0] = system_flag_irq_enable;
    end else if (s_axi_araddr[11:2] == urb_pkg::IDX_REPEATER) begin
      next_rdata[7:0] = serial_repeater_control;
    end else if (s_axi_araddr[11:2] == urb_pkg::IDX_BAUD_AUX) begin
      next_rdata[7:0] = serial_baud_aux_control;
    end else if (s_axi_araddr[11:2] == urb_pkg::IDX_SERIAL_CTL) begin
      next_rdata[urb_pkg::SCTL_MODE_BIT0] = power_and_baud_control[urb_pkg::FRAME_ERR_SEL_BIT] ?
                                            framing_error_flag : serial_mode_bit0; // R2
      next_rdata[urb_pkg::SCTL_MODE_BIT1] = serial_mode_bit1;
    end else if (s_axi_araddr[11:2] == urb_pkg::IDX_IRQ_STATUS) begin
      next_rdata[1:0] = irq_status;
    end else if (s_axi_araddr[11:2] == urb_pkg::IDX_IRQ_MASK) begin
      next_rdata[1:0] = irq_mask;
    end else begin
      next_rhit = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= urb_pkg::RESP_OKAY;
    end else if (s_axi_arready && s_axi_arvalid) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rhit ? urb_pkg::RESP_OKAY : urb_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // interrupt status and line
  // ----------------------------------------------------------------
  // write one to clear, a same-cycle event keeps the bit set
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_status <= urb_pkg::RST_IRQ;
      tx_done_d  <= 1'b0;
      irq        <= 1'b0;
    end else begin
      tx_done_d <= tx_done_flag;
      irq       <= |(irq_status & irq_mask);
      for (int i = 0; i < 2; i++) begin
        if ((i == urb_pkg::IRQ_FRAME_ERR_BIT && frame_err_evt) ||
            (i == urb_pkg::IRQ_TX_DONE_BIT && tx_done_flag && !tx_done_d)) begin
          irq_status[i] <= 1'b1;
        end else if (wr_fire && wr_be && wr_idx == urb_pkg::IDX_IRQ_STATUS && wr_byte[i]) begin
          irq_status[i] <= 1'b0;
        end
      end
    end
  end

  // transmit done routing to serial and system flag interrupts
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      serial_tx_irq  <= 1'b0;
      sysflag_tx_irq <= 1'b0;
    end else begin
      serial_tx_irq  <= tx_done_flag && !serial_baud_aux_control[urb_pkg::TX_IRQ_BLOCK_BIT]; // R8
      sysflag_tx_irq <= tx_done_flag && system_flag_irq_enable[urb_pkg::TX_SHARE_SYSFLAG_BIT]; // R12
    end
  end

  // ----------------------------------------------------------------
  // baud configuration outputs
  // ----------------------------------------------------------------
  assign repeat_mode = serial_mode_bit0 || serial_mode_bit1;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      serial_mode      <= 2'h0;
      baud_double      <= 1'b0;
      extra_rate       <= 1'b0;
      serial_test_mode <= 1'b0;
      mode0_tick       <= 1'b0;
      timer1_tick      <= 1'b0;
    end else begin
      serial_mode      <= {serial_mode_bit0, serial_mode_bit1};
      baud_double      <= power_and_baud_control[urb_pkg::BAUD_DOUBLE_EN_BIT] && repeat_mode; // R1
      extra_rate       <= serial_baud_aux_control[urb_pkg::EXTRA_RATE_SEL_BIT]; // R10
      serial_test_mode <= serial_baud_aux_control[urb_pkg::SERIAL_TEST_MODE_BIT];
      mode0_tick       <= m0_raw;
      timer1_tick      <= t1_raw;
    end
  end

  // mode 0 shift clock and timer 1 input clock dividers
  urb_prescaler u_mode0_div (
    .core_clk  (core_clk),
    .arst_n    (arst_n),
    .div_ratio (serial_baud_aux_control[urb_pkg::MODE0_RATE_SEL_BIT] ?
                urb_pkg::DIV_M0_FAST : urb_pkg::DIV_SLOW), // R9
    .tick      (m0_raw)
  );

  urb_prescaler u_timer1_div (
    .core_clk  (core_clk),
    .arst_n    (arst_n),
    .div_ratio (serial_baud_aux_control[urb_pkg::TIMER1_CLK_SEL_BIT] ?
                urb_pkg::DIV_NONE : urb_pkg::DIV_SLOW), // R11
    .tick      (t1_raw)
  );

  // ----------------------------------------------------------------
  // receive selection and repeater
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_meta <= '1;
      rx_sync <= '1;
    end else begin
      rx_meta <= rx_pin;
      rx_sync <= rx_meta;
    end
  end

  assign sel_rx = rx_sync[serial_repeater_control[urb_pkg::RX_CHANNEL_LSB +: 2]]; // R5

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_to_engine <= 1'b1;
    end else begin
      rx_to_engine <= sel_rx; // R14
    end
  end

  // each output repeats the selected input or carries its own function
  for (genvar g = 0; g < N_CH; g++) begin : g_rep
    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        tx_pin[g] <= 1'b1;
      end else if (serial_repeater_control[urb_pkg::REPEAT_EN_LSB + g] && repeat_mode) begin
        tx_pin[g] <= sel_rx; // R4 R13 R14 R16
      end else begin
        tx_pin[g] <= tx_func[g]; // R16
      end
    end

    a_repeat_route: assert property (@(posedge core_clk) disable iff (!arst_n) // R4
      serial_repeater_control[urb_pkg::REPEAT_EN_LSB + g] && repeat_mode |=> tx_pin[g] == $past(sel_rx))
      else $error("repeated output does not follow selected input");
    a_mode0_norepeat: assert property (@(posedge core_clk) disable iff (!arst_n) // R13
      !repeat_mode |=> tx_pin[g] == $past(tx_func[g]))
      else $error("mode 0 output not on its own function");
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  logic [3:0] m0_gap;
  logic       m0_seen;

  // cycles since the last mode 0 tick; the gap is only meaningful once a tick has been seen
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      m0_gap  <= 4'h0;
      m0_seen <= 1'b0;
    end else begin
      m0_gap  <= mode0_tick ? 4'h1 : m0_gap + 4'h1;
      m0_seen <= m0_seen || mode0_tick;
    end
  end

  a_fe_sets: assert property (@(posedge core_clk) disable iff (!arst_n) // R3
    frame_err_evt |=> framing_error_flag)
    else $error("framing error flag not set by frame error");
  a_fe_sticky: assert property (@(posedge core_clk) disable iff (!arst_n) // R15
    framing_error_flag && !wr_fire |=> framing_error_flag)
    else $error("framing error flag dropped without software");
  a_rx_select: assert property (@(posedge core_clk) disable iff (!arst_n) // R5
    ##1 rx_to_engine == rx_sync[$past(serial_repeater_control[1:0])] || $changed(rx_sync))
    else $error("engine input not from selected channel");
  a_tx_block: assert property (@(posedge core_clk) disable iff (!arst_n) // R8
    serial_baud_aux_control[urb_pkg::TX_IRQ_BLOCK_BIT] |=> !serial_tx_irq)
    else $error("blocked transmit done reached serial interrupt");
  a_tx_share: assert property (@(posedge core_clk) disable iff (!arst_n) // R12
    tx_done_flag && system_flag_irq_enable[urb_pkg::TX_SHARE_SYSFLAG_BIT] |=> sysflag_tx_irq)
    else $error("shared transmit done missing on system flag interrupt");
  a_baud_double: assert property (@(posedge core_clk) disable iff (!arst_n) // R1
    baud_double |-> $past(repeat_mode) && $past(power_and_baud_control[7]))
    else $error("baud doubling outside modes 1 to 3");
  a_extra_rate: assert property (@(posedge core_clk) disable iff (!arst_n) // R10
    ##1 extra_rate == $past(serial_baud_aux_control[urb_pkg::EXTRA_RATE_SEL_BIT]))
    else $error("extra rate output wrong");
  a_mode0_slow: assert property (@(posedge core_clk) disable iff (!arst_n) // R9
    mode0_tick && m0_seen && !serial_baud_aux_control[5] && !$past(serial_baud_aux_control[5], 13)
    |-> m0_gap == 4'hc)
    else $error("mode 0 clock not divided by 12");
  a_timer1_fast: assert property (@(posedge core_clk) disable iff (!arst_n) // R11
    serial_baud_aux_control[3] && $past(serial_baud_aux_control[3], 14) |-> timer1_tick)
    else $error("timer 1 not on undivided clock");
  a_irq_level: assert property (@(posedge core_clk) disable iff (!arst_n)
    ##1 irq == |($past(irq_status) & $past(irq_mask)))
    else $error("interrupt line does not follow status and mask");

  c_repeat_all: cover property (@(posedge core_clk) disable iff (!arst_n)
    repeat_mode && serial_repeater_control[7:4] == 4'hf);
  c_fe_view: cover property (@(posedge core_clk) disable iff (!arst_n)
    framing_error_flag && power_and_baud_control[urb_pkg::FRAME_ERR_SEL_BIT] && s_axi_rvalid);
  c_irq: cover property (@(posedge core_clk) disable iff (!arst_n) irq);

endmodule
